/* design/mcc_drive_end.sv */
`timescale 1ns/1ps
module mcc_drive_end
    import mcc_pkg::*;
(
    input  wire logic       core_clk,
    input  wire logic       rst,
    mcc_link_if.slave       link,
    input  wire logic [6:0] node_addr,
    output logic            frame_ok,
    output logic            crc_error,
    output logic [15:0]     frame_check_compute,
    output logic            addr_valid
);
    import mcc_pkg::*;
    // Two held bytes delay the CRC so the trailing pair stays out of it
    logic [15:0] crc_accumulator_q;
    logic [7:0]  check_low_byte_q;
    logic [7:0]  check_high_byte_q;
    logic [1:0]  held_q;
    logic        ok_q;
    logic        err_q;
    logic [15:0] res_q;

    wire  [15:0] crc_nx = mcc_crc_byte(crc_accumulator_q, check_low_byte_q); // R3
    wire  [15:0] rx_crc = {check_high_byte_q, check_low_byte_q}; // R1
    wire         match  = (crc_accumulator_q == rx_crc) && (held_q == 2'd2);

    assign frame_ok  = ok_q;
    assign crc_error = err_q;
    assign frame_check_compute = res_q;
    // Slave-only node; address range checked here, no master logic exists
    assign addr_valid = (node_addr >= ADDR_MIN) && (node_addr <= ADDR_MAX); // R7

    // ==========================================
    // Frame checker
    always_ff @(posedge core_clk) begin
        if (rst) begin
            crc_accumulator_q <= CRC_SEED;
            check_low_byte_q <= 8'h00;
            check_high_byte_q <= 8'h00;
            held_q <= 2'd0;
            ok_q <= 1'b0;
            err_q <= 1'b0;
            res_q <= 16'h0;
        end else begin
            ok_q <= 1'b0;
            err_q <= 1'b0;
            if (link.frame_end) begin
                res_q <= crc_accumulator_q;
                ok_q <= match && addr_valid; // R8
                err_q <= !match; // R4 R9
                crc_accumulator_q <= CRC_SEED; // R2
                held_q <= 2'd0;
            end else if (link.byte_valid) begin
                check_low_byte_q <= check_high_byte_q;
                check_high_byte_q <= link.byte_data;
                if (held_q == 2'd2) begin
                    crc_accumulator_q <= crc_nx; // R9
                end else begin
                    held_q <= held_q + 2'd1;
                end
            end
        end
    end
endmodule : mcc_drive_end

/* design/mcc_host_end.sv */
`timescale 1ns/1ps
module mcc_host_end
    import mcc_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst,
    mcc_link_if.master       link,
    input  wire logic        tx_valid,
    input  wire logic [7:0]  tx_byte,
    input  wire logic        tx_last,
    output logic             tx_ready,
    input  wire logic        enc_32,
    input  wire logic [31:0] enc_value,
    output logic [31:0]      enc_word
);
    import mcc_pkg::*;
    typedef enum {H_IDLE, H_DATA, H_CHECK_LOW_BYTE, H_CHECK_HIGH_BYTE, H_GAP} mcc_hst_t;
    mcc_hst_t    st_q;
    logic [15:0] crc_accumulator_q;
    logic [7:0]  data_q;
    logic        valid_q;
    logic        end_q;
    logic [31:0] gap_q;
    logic [31:0] enc_word_q;

    // ==========================================
    // Signed value encoding
    wire         neg16   = enc_value[15];
    wire  [15:0] mag16   = neg16 ? (~enc_value[15:0] + 16'h0001) : enc_value[15:0];
    wire  [15:0] tc16    = neg16 ? (16'hffff - mag16 + 16'h0001) : mag16; // R5
    wire         neg32   = enc_value[31];
    wire  [31:0] mag32   = neg32 ? (~enc_value + 32'h00000001) : enc_value;
    wire  [31:0] tc32    = neg32 ? (~mag32 + 32'h00000001) : mag32; // R6
    wire  [31:0] enc_sel = enc_32 ? tc32 : {16'h0000, tc16};

    wire         take    = tx_valid && tx_ready;
    wire  [15:0] crc_nx  = mcc_crc_byte(crc_accumulator_q, tx_byte); // R3
    assign tx_ready      = (st_q == H_IDLE) || (st_q == H_DATA);
    assign link.byte_valid = valid_q;
    assign link.byte_data  = data_q;
    assign link.frame_end  = end_q;
    assign enc_word        = enc_word_q;

    // ==========================================
    // Frame sender
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_q <= H_IDLE;
            crc_accumulator_q <= CRC_SEED;
            data_q <= 8'h00;
            valid_q <= 1'b0;
            end_q <= 1'b0;
            gap_q <= 32'h0;
            enc_word_q <= 32'h0;
        end else begin
            enc_word_q <= enc_sel;
            valid_q <= 1'b0;
            end_q <= 1'b0;
            case (st_q)
                H_IDLE, H_DATA: begin
                    if (take) begin
                        valid_q <= 1'b1;
                        data_q <= tx_byte;
                        crc_accumulator_q <= crc_nx;
                        st_q <= tx_last ? H_CHECK_LOW_BYTE : H_DATA;
                    end
                end
                H_CHECK_LOW_BYTE: begin
                    valid_q <= 1'b1;
                    data_q <= crc_accumulator_q[7:0]; // R1
                    st_q <= H_CHECK_HIGH_BYTE;
                end
                H_CHECK_HIGH_BYTE: begin
                    valid_q <= 1'b1;
                    data_q <= crc_accumulator_q[15:8]; // R1
                    gap_q <= 32'(IDLE_CYC);
                    st_q <= H_GAP;
                end
                H_GAP: begin
                    // Silence on the line closes the frame
                    if (gap_q == 32'h0) begin
                        end_q <= 1'b1; // R8
                        crc_accumulator_q <= CRC_SEED; // R2
                        st_q <= H_IDLE;
                    end else begin
                        gap_q <= gap_q - 32'h1;
                    end
                end
                default: st_q <= H_IDLE;
            endcase
        end
    end
endmodule : mcc_host_end

/* design/mcc_link_if.sv */
`timescale 1ns/1ps
interface mcc_link_if;
    logic       byte_valid;
    logic [7:0] byte_data;
    logic       frame_end;
    modport master (output byte_valid, output byte_data, output frame_end);
    modport slave  (input byte_valid, input byte_data, input frame_end);
endinterface : mcc_link_if

/* design/mcc_pkg.sv */
// Behaviour
// R1: 16-bit check, low byte then high byte
// R2: Accumulator preset to all ones per frame
// R3: XOR byte low, eight reflected shift steps
// R4: Mismatching check value flags a CRC error
// R5: Signed 16-bit values sent as two's complement
// R6: Signed 32-bit values sent as two's complement
// R7: Slave only, single master, address 1..63
// R8: Frame bounded by 3.5 character idle time
// R9: Check all but last two; discard mismatch
package mcc_pkg;
    localparam logic [15:0] CRC_SEED     = 16'hffff;
    localparam logic [15:0] CRC_POLY     = 16'ha001;
    localparam int          CRC_STEPS    = 8;
    localparam int          CLK_HZ       = 25000000;
    // Fast line rate keeps the idle gap to 8354 clocks
    localparam int          BAUD         = 115200;
    localparam int          CHAR_BITS    = 11;
    // Idle time in tenths of a character: 3.5 characters
    localparam int          IDLE_TENTHS  = 35;
    localparam int          IDLE_CYC     = (CLK_HZ / BAUD) * CHAR_BITS * IDLE_TENTHS / 10;
    localparam logic [6:0]  ADDR_MIN     = 7'h01;
    localparam logic [6:0]  ADDR_MAX     = 7'h3f;

    function automatic logic [15:0] mcc_crc_byte(input logic [15:0] acc, input logic [7:0] data);
        logic [15:0] c;
        c = acc ^ {8'h00, data};
        for (int i = 0; i < CRC_STEPS; i++) begin
            c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        end
        return c;
    endfunction : mcc_crc_byte
endpackage : mcc_pkg

/* tb/mcc_link_chk.sv */
`timescale 1ns/1ps
module mcc_link_chk (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       byte_valid,
    input wire logic       frame_end,
    input wire logic       frame_ok,
    input wire logic       crc_error,
    input wire logic       addr_valid,
    input wire logic [6:0] node_addr
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    AST_OK_CAUSE: assert property (frame_ok |-> $past(frame_end)) else $error("ok w/o end");
    AST_ERR_CAUSE: assert property (crc_error |-> $past(frame_end)) else $error("err w/o end");
    AST_ONE_VERDICT: assert property (!(frame_ok && crc_error)) else $error("two verdicts");
    AST_ADDR: assert property (addr_valid == (node_addr >= 7'h01 && node_addr <= 7'h3f)) else $error("addr");
    AST_OK_ADDR: assert property (frame_ok |-> addr_valid) else $error("ok bad addr");
    AST_END_PULSE: assert property (frame_end |=> !frame_end) else $error("end width");
    AST_END_IDLE: assert property (frame_end |-> !byte_valid && !$past(byte_valid)) else $error("no idle");
    AST_DUE: assert property (frame_end |=> frame_ok || crc_error) else $error("no verdict");
    cover property (frame_ok);
    cover property (byte_valid ##1 byte_valid);
    cover property (frame_end);
endmodule : mcc_link_chk

/* tb/tb_modbus_crc16_signed_codec.sv */
`timescale 1ns/1ps
module tb_modbus_crc16_signed_codec;
    import mcc_pkg::*;
    logic        core_clk = 0, rst = 1, tx_valid = 0, tx_last = 0, enc_32 = 0;
    logic        tx_ready, frame_ok, crc_error, av, ok2, err2, av2;
    logic [7:0]  tx_byte = 0, exp_b[$], f[$];
    logic [31:0] enc_value = 0, enc_word, ev;
    logic [15:0] fcc2, fcc, c;
    logic [6:0]  addr2 = 7'h05;
    logic        exp_s[$];
    int          n_mismatch = 0, checks_done = 0, n, v;
    mcc_link_if link();
    mcc_link_if link2();
    mcc_host_end mcc_host_end_inst (.core_clk(core_clk), .rst(rst), .link(link), .tx_valid(tx_valid),
        .tx_byte(tx_byte), .tx_last(tx_last), .tx_ready(tx_ready), .enc_32(enc_32), .enc_value(enc_value),
        .enc_word(enc_word));
    mcc_drive_end mcc_drive_end_inst (.core_clk(core_clk), .rst(rst), .link(link), .node_addr(7'h01),
        .frame_ok(frame_ok), .crc_error(crc_error), .frame_check_compute(fcc), .addr_valid(av));
    mcc_drive_end mcc_drive_end_inst2 (.core_clk(core_clk), .rst(rst), .link(link2), .node_addr(addr2),
        .frame_ok(ok2), .crc_error(err2), .frame_check_compute(fcc2), .addr_valid(av2));
    mcc_link_chk mcc_link_chk_inst (.core_clk(core_clk), .rst(rst), .byte_valid(link.byte_valid),
        .frame_end(link.frame_end), .frame_ok(frame_ok), .crc_error(crc_error), .addr_valid(av),
        .node_addr(7'h01));
    always #20 core_clk = ~core_clk;
    task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
        checks_done++;
        if (s !== e) begin
            n_mismatch++;
            $display("ERROR %s exp %h got %h", nm, e, s);
        end
    endtask : chk
    function automatic logic [15:0] crc(logic [7:0] q[$]);
        logic [15:0] a;
        a = 16'hffff;
        foreach (q[i]) begin
            a ^= q[i];
            repeat (8) a = a[0] ? (a >> 1) ^ 16'ha001 : a >> 1;
        end
        return a;
    endfunction : crc
    task automatic step;
        @(posedge core_clk);
        #1;
    endtask : step
    task automatic put(logic [7:0] b, logic vl, logic e);
        link2.byte_valid = vl;
        link2.byte_data = vl ? b : ~b;
        link2.frame_end = e;
        step();
    endtask : put
    task automatic feed(logic [15:0] k, logic ok);
        foreach (f[i]) put(f[i], 1, 0);
        put(k[7:0], 1, 0);
        put(k[15:8], 1, 0);
        put(8'h00, 0, 1);
        // Verdict pulses last one cycle: look before the idle beat
        chk("ok2", ok, ok2);
        chk("err2", !ok && addr2 != 0, err2);
        chk("fcc2", crc(f), fcc2);
        put(8'h00, 0, 0);
    endtask : feed
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    // Sampled mid-cycle, away from the edge that launches the outputs
    always @(negedge core_clk) begin
        if (link.byte_valid) chk("link byte", exp_b.pop_front(), link.byte_data);
        if (frame_ok | crc_error) chk("verdict", exp_s.pop_front(), frame_ok);
    end
    initial begin
        put(8'h00, 0, 0);
        void'($urandom(81281));
        repeat (20) step();
        rst = 0;
        for (n = 0; n < 16; n++) begin
            v = n == 0 ? -100 : n < 8 ? int'($signed(16'($urandom))) : int'($urandom);
            enc_value = v;
            enc_32 = n >= 8;
            step();
            ev = v < 0 ? 32'hffffffff - 32'(-v) + 32'h1 : 32'(v);
            if (!enc_32) ev = {16'h0, 16'(v < 0 ? 16'hffff - 16'(-v) + 16'h1 : v)};
            chk("enc", ev, enc_word);
        end
        $display("encode test done");
        f = '{8'h01, 8'h03, 8'h02, 8'h02, 8'h00, 8'h02};
        feed(crc(f), 1);
        feed(crc(f) ^ 16'h0100, 0);
        addr2 = 0;
        feed(crc(f), 0);
        foreach (f[i]) begin
            addr2 = 7'(i * 32);
            step();
            chk("addr_valid", addr2 >= 7'h01 && addr2 <= 7'h3f, av2);
        end
        $display("drive end test done");
        f = '{8'h01, 8'($urandom), 8'($urandom)};
        c = crc(f);
        exp_b = '{f[0], f[1], f[2], c[7:0], c[15:8]};
        exp_s = '{1'b1};
        foreach (f[i]) begin
            {tx_valid, tx_byte, tx_last} = {1'b1, f[i], i == 2};
            step();
        end
        tx_valid = 0;
        chk("refused", 0, tx_ready);
        for (n = 0; n < IDLE_CYC + 20 && !link.frame_end; n++) step();
        chk("frame_end", 1, link.frame_end);
        step();
        step();
        chk("left", 0, exp_b.size() + exp_s.size());
        chk("fcc", c, fcc);
        $display("host frame test done");
        print_verdict();
    end
endmodule : tb_modbus_crc16_signed_codec
